// ===== omr_pkg.sv
// shared constants, command codes and carrier types for the output mode / range / status block
`default_nettype none
package omr_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_TIME_US  = 1000;   // one unit of transient duration
    localparam int unsigned TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

    // ****************************************
    // scaling and ranges
    // ****************************************
    localparam logic [15:0] FULL_SCALE_CODE = 16'hffff;
    localparam logic [15:0] QUARTER_CODE    = FULL_SCALE_CODE >> 2;
    localparam logic [15:0] RANGE_FULL      = 16'h0001;
    localparam logic [15:0] RANGE_QUARTER   = 16'h0004;

    // ****************************************
    // status structure
    // ****************************************
    localparam int unsigned CC_BIT    = 10;
    localparam int unsigned CV_BIT    = 8;
    localparam logic [15:0] COND_MASK = 16'h0521;   // 1313
    localparam logic [15:0] ENAB_RST  = 16'h0000;
    localparam logic [15:0] EVT_RST   = 16'h0000;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [15:0] DUR_RST   = 16'h0001;

    // ****************************************
    // error codes, two's complement
    // ****************************************
    localparam logic [15:0] ERR_COMMAND    = 16'hff9c;  // -100
    localparam logic [15:0] ERR_CONFLICT   = 16'hff23;  // -221
    localparam logic [15:0] ERR_DATA_RANGE = 16'hff22;  // -222
    localparam logic [15:0] ERR_PARAM      = 16'hff20;  // -224

    // ****************************************
    // mode query replies
    // ****************************************
    localparam logic [15:0] REPLY_FIXED = 16'h0000;
    localparam logic [15:0] REPLY_LIST  = 16'h0001;
    localparam logic [15:0] REPLY_TRANS = 16'h0002;

    typedef enum logic [4:0] {
        OP_NOP       = 5'h00, OP_SET_LEVEL = 5'h01, OP_SET_CURR  = 5'h02, OP_SET_LIMIT = 5'h03,
        OP_MODE_FIX  = 5'h04, OP_MODE_LIST = 5'h05, OP_MODE_TRAN = 5'h06, OP_QRY_MODE  = 5'h07,
        OP_SET_RANGE = 5'h08, OP_QRY_RANGE = 5'h09, OP_AUTO_V    = 5'h0a, OP_AUTO_C    = 5'h0b,
        OP_SET_TRIG  = 5'h0c, OP_QRY_TRIG  = 5'h0d, OP_TRIGGER   = 5'h0e, OP_QRY_COND  = 5'h0f,
        OP_SET_ENAB  = 5'h10, OP_QRY_ENAB  = 5'h11, OP_QRY_EVT   = 5'h12, OP_RESET     = 5'h13,
        OP_FUNC_MODE = 5'h14, OP_SEQ_LEVEL = 5'h15, OP_SEQ_CURR  = 5'h16, OP_QRY_LEVEL = 5'h17
    } omr_op_t;

    typedef enum logic [3:0] {
        MODE_FIXED = 4'b0001,
        MODE_LIST  = 4'b0010,
        MODE_ARMED = 4'b0100,
        MODE_PULSE = 4'b1000
    } omr_mode_t;

    typedef struct packed {
        logic        valid;
        omr_op_t     op;
        logic [15:0] arg;
    } omr_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } omr_ans_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } omr_err_t;

endpackage
`default_nettype wire

// ===== omr_pulse_timer.sv
// transient duration timer: counts whole ticks derived from the system clock
`timescale 1ns/100ps
`default_nettype none
module omr_pulse_timer
    import omr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = omr_pkg::TICK_CYCLES,
    parameter int unsigned DUR_W       = 16
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             start_i,
    input  wire logic             stop_i,
    input  wire logic [DUR_W-1:0] dur_i,
    // status
    output logic                  expire_o
);

    localparam int unsigned    TW        = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TW-1:0]  TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic             run;
        logic [TW-1:0]    tick;
        logic [DUR_W-1:0] left;
    } omr_tmr_state_t;

    omr_tmr_state_t s, n;
    logic           tick_end;

    always_comb begin
        n        = s;
        tick_end = (s.tick == TICK_LAST);
        // a zero duration still lasts one tick
        expire_o = s.run && tick_end && (s.left <= DUR_W'(1));
        if (start_i) begin
            n.run  = 1'b1;
            n.tick = '0;
            n.left = dur_i;
        end else if (stop_i || expire_o) begin
            n.run = 1'b0;
        end else if (s.run) begin
            n.tick = tick_end ? '0 : TW'(s.tick + 1'b1);
            if (tick_end) begin
                n.left = DUR_W'(s.left - 1'b1);
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule // omr_pulse_timer
`default_nettype wire

// ===== omr_core.sv
// command interpreter for output mode, ranging, triggered level and operation status
`timescale 1ns/100ps
`default_nettype none
module omr_core
    import omr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = omr_pkg::TICK_CYCLES,
    parameter logic [15:0] MAX_LEVEL   = 16'hffff,
    parameter int unsigned DUR_W       = 16
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // command and answers
    input  wire omr_req_t    req_i,
    output omr_ans_t         ans_o,
    output omr_err_t         err_o,
    // sequencer handshake
    input  wire logic        seq_done_i,
    output logic             seq_run_o,
    // regulation pins
    input  wire logic        constant_current_flag_i,
    input  wire logic        constant_level_flag_i,
    // output settings
    output logic [15:0]      level_o,
    output logic [15:0]      curr_set_o,
    output logic [15:0]      curr_lim_o,
    output logic [15:0]      dac_code_o,
    output logic             current_mode_o,
    output logic             auto_scale_enable_o,
    output logic             op_summary_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        omr_mode_t   mode;
        logic        cur_mode;
        logic        auto_en;
        logic        v_quarter;
        logic        c_quarter;
        logic [15:0] level;
        logic [15:0] curr_set;
        logic [15:0] curr_lim;
        logic [15:0] saved;
        logic [15:0] trig;
        logic [15:0] upper_level_limit;
        logic [15:0] enab;
        logic [15:0] evt;
        logic [15:0] dac;
        logic [15:0] dur;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  cond_q;
        omr_ans_t    ans;
        omr_err_t    err;
        logic        summary;
    } omr_state_t;

    localparam omr_state_t ST_RST = '{
        mode: MODE_FIXED, cur_mode: 1'b0, auto_en: 1'b1, v_quarter: 1'b0, c_quarter: 1'b0,
        level: LEVEL_RST, curr_set: LEVEL_RST, curr_lim: LEVEL_RST, saved: LEVEL_RST,
        trig: LEVEL_RST, upper_level_limit: MAX_LEVEL, enab: ENAB_RST, evt: EVT_RST,
        dac: LEVEL_RST, dur: DUR_RST, sync1: 2'h0, sync2: 2'h0, cond_q: 2'h0,
        ans: '0, err: '0, summary: 1'b0
    };

    omr_state_t  s, n;
    logic [15:0] cond;
    logic [15:0] rise;
    logic [15:0] sel_val;
    logic [15:0] op_arg;
    logic        tmr_start;
    logic        tmr_stop;
    logic        tmr_expire;

    // quarter-scale choice of the active function
    function automatic logic eff_quarter(input omr_state_t st);
        logic [15:0] v;
        v = st.cur_mode ? st.curr_set : st.level;
        if (st.auto_en) begin
            eff_quarter = (v <= QUARTER_CODE);
        end else begin
            eff_quarter = st.cur_mode ? st.c_quarter : st.v_quarter;
        end
    endfunction

    // ****************************************
    // transient timer
    // ****************************************
    omr_pulse_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .DUR_W       (DUR_W)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (tmr_start),
        .stop_i     (tmr_stop),
        .dur_i      (s.dur[DUR_W-1:0]),
        .expire_o   (tmr_expire)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n         = s;
        tmr_start = 1'b0;
        tmr_stop  = 1'b0;
        op_arg    = req_i.arg;
        n.ans     = '0;
        n.err     = '0;
        // live condition view, only the two regulation bits exist
        cond         = '0;
        cond[CC_BIT] = s.sync2[1];
        cond[CV_BIT] = s.sync2[0];
        rise         = cond & ~{5'h00, s.cond_q[1], 1'b0, s.cond_q[0], 8'h00};
        n.sync1      = {constant_current_flag_i, constant_level_flag_i};
        n.sync2      = s.sync1;
        n.cond_q     = s.sync2;
        // the rise is or'ed in last so it survives a clearing read
        if (req_i.valid && req_i.op == OP_QRY_EVT) begin
            n.evt = '0;
        end
        n.evt = n.evt | rise;

        if (s.mode == MODE_PULSE && tmr_expire) begin
            n.level = s.saved;
            n.mode  = MODE_FIXED;
        end
        if (s.mode == MODE_LIST && seq_done_i) begin
            n.mode = MODE_FIXED;
        end

        if (req_i.valid) begin
            case (req_i.op)
                OP_SET_LEVEL, OP_TRIGGER: begin
                    if (req_i.op == OP_TRIGGER) begin
                        op_arg = s.trig;
                    end
                    if (op_arg > MAX_LEVEL) begin
                        n.err = '{valid: 1'b1, code: ERR_DATA_RANGE};
                    end else if (s.mode == MODE_ARMED) begin
                        n.saved   = s.level;
                        n.level   = op_arg;
                        n.mode    = MODE_PULSE;
                        tmr_start = 1'b1;
                    end else begin
                        n.level = op_arg;
                    end
                end
                OP_SET_CURR: begin
                    n.curr_set = req_i.arg;
                end
                OP_SET_LIMIT: begin
                    if (req_i.arg > MAX_LEVEL) begin
                        n.err = '{valid: 1'b1, code: ERR_DATA_RANGE};
                    end else begin
                        n.upper_level_limit = req_i.arg;
                    end
                end
                OP_MODE_FIX: begin
                    if (s.mode == MODE_LIST) begin
                        n.level    = '0;
                        n.curr_set = '0;
                        n.curr_lim = '0;
                    end
                    tmr_stop = 1'b1;
                    n.mode   = MODE_FIXED;
                end
                OP_MODE_LIST: begin
                    if (s.mode != MODE_LIST) begin
                        n.curr_lim = s.curr_set;
                        n.mode     = MODE_LIST;
                    end
                end
                OP_MODE_TRAN: begin
                    if (s.mode == MODE_LIST) begin
                        n.err = '{valid: 1'b1, code: ERR_CONFLICT};
                    end else begin
                        n.dur    = req_i.arg;
                        n.mode   = MODE_ARMED;
                        tmr_stop = 1'b1;
                    end
                end
                OP_QRY_MODE: begin
                    n.ans.valid = 1'b1;
                    case (s.mode)
                        MODE_LIST:  n.ans.data = REPLY_LIST;
                        MODE_ARMED: n.ans.data = REPLY_TRANS;
                        default:    n.ans.data = REPLY_FIXED;
                    endcase
                end
                OP_SET_RANGE: begin
                    if (req_i.arg == RANGE_FULL || req_i.arg == RANGE_QUARTER) begin
                        n.auto_en = 1'b0;
                        if (s.cur_mode) begin
                            n.c_quarter = (req_i.arg == RANGE_QUARTER);
                        end else begin
                            n.v_quarter = (req_i.arg == RANGE_QUARTER);
                        end
                    end else begin
                        n.err = '{valid: 1'b1, code: ERR_PARAM};
                    end
                end
                OP_QRY_RANGE: begin
                    n.ans = '{valid: 1'b1, data: eff_quarter(s) ? RANGE_QUARTER : RANGE_FULL};
                end
                OP_AUTO_V, OP_AUTO_C: begin
                    if (req_i.arg == 16'h0000) begin
                        // freeze the range that auto had chosen
                        n.auto_en = 1'b0;
                        if (s.cur_mode) begin
                            n.c_quarter = eff_quarter(s);
                        end else begin
                            n.v_quarter = eff_quarter(s);
                        end
                    end else if (req_i.arg == 16'h0001) begin
                        n.auto_en = 1'b1;
                    end else begin
                        n.err = '{valid: 1'b1, code: ERR_PARAM};
                    end
                end
                OP_SET_TRIG: begin
                    if (req_i.arg > MAX_LEVEL) begin
                        n.err = '{valid: 1'b1, code: ERR_DATA_RANGE};
                    end else if (req_i.arg > s.upper_level_limit) begin
                        n.trig = s.upper_level_limit;
                    end else begin
                        n.trig = req_i.arg;
                    end
                end
                OP_QRY_TRIG:  n.ans = '{valid: 1'b1, data: s.trig};
                OP_QRY_LEVEL: n.ans = '{valid: 1'b1, data: s.level};
                OP_QRY_COND:  n.ans = '{valid: 1'b1, data: cond};
                OP_SET_ENAB:  n.enab = req_i.arg & COND_MASK;
                OP_QRY_ENAB:  n.ans = '{valid: 1'b1, data: s.enab};
                OP_QRY_EVT:   n.ans = '{valid: 1'b1, data: s.evt};
                OP_RESET: begin
                    n.level    = LEVEL_RST;
                    n.curr_set = LEVEL_RST;
                    n.cur_mode = 1'b0;
                    n.auto_en  = 1'b1;
                    n.mode     = MODE_FIXED;
                    tmr_stop   = 1'b1;
                end
                OP_FUNC_MODE, OP_SEQ_LEVEL, OP_SEQ_CURR: begin
                    if (s.mode == MODE_LIST) begin
                        n.err = '{valid: 1'b1, code: ERR_CONFLICT};
                    end else if (req_i.op == OP_FUNC_MODE) begin
                        n.cur_mode = req_i.arg[0];
                    end
                end
                OP_NOP: begin
                end
                default: begin
                    n.err = '{valid: 1'b1, code: ERR_COMMAND};
                end
            endcase
        end

        // converter code for the active function
        sel_val = n.cur_mode ? n.curr_set : n.level;
        if (eff_quarter(n)) begin
            n.dac = (sel_val > QUARTER_CODE) ? FULL_SCALE_CODE : {sel_val[13:0], 2'b00};
        end else begin
            n.dac = sel_val;
        end
        n.summary = |(n.evt & n.enab);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign ans_o               = s.ans;
    assign err_o               = s.err;
    assign seq_run_o           = (s.mode == MODE_LIST);
    assign level_o             = s.level;
    assign curr_set_o          = s.curr_set;
    assign curr_lim_o          = s.curr_lim;
    assign dac_code_o          = s.dac;
    assign current_mode_o      = s.cur_mode;
    assign auto_scale_enable_o = s.auto_en;
    assign op_summary_o        = s.summary;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_arm;
        req_i.valid && req_i.op == OP_MODE_TRAN && s.mode == MODE_FIXED;
    endsequence

    sequence seq_level_after_arm;
        req_i.valid && req_i.op == OP_SET_LEVEL && req_i.arg <= MAX_LEVEL && s.mode == MODE_ARMED;
    endsequence

    chk_list_rejects_func: assert property (
        (req_i.valid && req_i.op == OP_FUNC_MODE && s.mode == MODE_LIST)
        |=> (err_o.valid && err_o.code == ERR_CONFLICT && $stable(current_mode_o)))
        else $error("function mode changed while list running");

    chk_fix_zeroes_outputs: assert property (
        (req_i.valid && req_i.op == OP_MODE_FIX && s.mode == MODE_LIST)
        |=> (level_o == 16'h0000 && curr_set_o == 16'h0000 && curr_lim_o == 16'h0000 && !seq_run_o))
        else $error("fixed mode did not zero the outputs");

    chk_pulse_applies_level: assert property (
        seq_arm ##[1:8] seq_level_after_arm |=> (s.mode == MODE_PULSE && level_o == $past(req_i.arg)))
        else $error("armed transient did not apply the new level");

    chk_pulse_restores: assert property (
        (s.mode == MODE_PULSE && tmr_expire && !req_i.valid) |=> (level_o == $past(s.saved) && s.mode == MODE_FIXED))
        else $error("transient did not restore the earlier level");

    chk_mode_reply_trans: assert property (
        (req_i.valid && req_i.op == OP_QRY_MODE && s.mode == MODE_ARMED)
        |=> (ans_o.valid && ans_o.data == REPLY_TRANS))
        else $error("mode query did not report transient");

    chk_range_clears_auto: assert property (
        (req_i.valid && req_i.op == OP_SET_RANGE && (req_i.arg == RANGE_FULL || req_i.arg == RANGE_QUARTER))
        |=> (!auto_scale_enable_o && !err_o.valid))
        else $error("range command left auto ranging on");

    chk_range_reply: assert property (
        (req_i.valid && req_i.op == OP_QRY_RANGE)
        |=> (ans_o.valid && (ans_o.data == RANGE_FULL || ans_o.data == RANGE_QUARTER)))
        else $error("range reply not 1 or 4");

    chk_auto_threshold: assert property (
        (auto_scale_enable_o && !current_mode_o && level_o > QUARTER_CODE) |-> (dac_code_o == level_o))
        else $error("auto ranging chose quarter above threshold");

    chk_trig_over_max: assert property (
        (req_i.valid && req_i.op == OP_SET_TRIG && req_i.arg > MAX_LEVEL)
        |=> (err_o.valid && err_o.code == ERR_DATA_RANGE && $stable(s.trig)))
        else $error("over-range triggered level not refused");

    chk_trig_clamp: assert property (
        (req_i.valid && req_i.op == OP_SET_TRIG && req_i.arg <= MAX_LEVEL && req_i.arg > s.upper_level_limit)
        |=> (s.trig == $past(s.upper_level_limit)))
        else $error("triggered level not clamped to limit");

    chk_summary_or: assert property (
        op_summary_o == (|(s.evt & s.enab)))
        else $error("summary bit disagrees with masked events");

    chk_event_rise_sticks: assert property (
        (cond[CC_BIT] && !s.cond_q[1]) |=> s.evt[CC_BIT])
        else $error("rising condition lost from event register");

    chk_read_clears: assert property (
        (req_i.valid && req_i.op == OP_QRY_EVT && rise == 16'h0000)
        |=> (ans_o.data == $past(s.evt) && s.evt == 16'h0000))
        else $error("event read did not return and clear");

endmodule // omr_core
`default_nettype wire

// ===== omr_host.sv
// host controller model that issues one command at a time
`timescale 1ns/100ps
`default_nettype none
module omr_host
    import omr_pkg::*;
(
    // clock
    input  wire logic     core_clk_i,
    // command
    output omr_req_t      req_o
);
    // ****************************************
    // command issue
    // ****************************************
    initial req_o = '0;
    // one valid cycle per command, changed only on the falling edge
    task automatic cmd(input omr_op_t op, input logic [15:0] arg);
        @(negedge core_clk_i);
        req_o = '{1'b1, op, arg};
        @(negedge core_clk_i);
        req_o = '0;
    endtask
endmodule // omr_host
`default_nettype wire

// ===== tb.sv
// self-checking bench for the output mode, range and status command block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import omr_pkg::*;
    // ****************************************
    // clock, design and checks
    // ****************************************
    typedef struct {omr_op_t op; logic [15:0] a; logic [1:0] k; logic [15:0] d;} omr_row_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cc_flag = 1'b0;
    logic cv_flag = 1'b0;
    logic seq_done = 1'b0;
    logic [15:0] level;
    logic [15:0] curr_set, curr_lim, dac;
    logic auto_on, summary, seq_run, cur_mode;
    int error_cnt = 0;
    int checks_done = 0;
    omr_req_t req;
    omr_ans_t ans;
    omr_err_t err;
    // k: 0 silent, 1 answer, 2 error
    omr_row_t rows[23] = '{
        '{OP_QRY_MODE, 16'h0, 2'h1, REPLY_FIXED},
        '{OP_SET_ENAB, 16'hffff, 2'h0, 16'h0}, '{OP_QRY_ENAB, 16'h0, 2'h1, 16'h0521},
        '{OP_SET_LEVEL, 16'h4000, 2'h0, 16'h0}, '{OP_QRY_RANGE, 16'h0, 2'h1, RANGE_FULL},
        '{OP_SET_LEVEL, 16'h3fff, 2'h0, 16'h0}, '{OP_QRY_RANGE, 16'h0, 2'h1, RANGE_QUARTER},
        '{OP_SET_RANGE, 16'h2, 2'h2, ERR_PARAM}, '{OP_SET_RANGE, 16'h1, 2'h0, 16'h0},
        '{OP_QRY_RANGE, 16'h0, 2'h1, RANGE_FULL},
        '{OP_SET_LIMIT, 16'h0100, 2'h0, 16'h0}, '{OP_SET_TRIG, 16'h0200, 2'h0, 16'h0},
        '{OP_QRY_TRIG, 16'h0, 2'h1, 16'h0100}, '{OP_QRY_LEVEL, 16'h0, 2'h1, 16'h3fff},
        '{OP_TRIGGER, 16'h0, 2'h0, 16'h0}, '{OP_QRY_LEVEL, 16'h0, 2'h1, 16'h0100},
        '{OP_SET_TRIG, 16'hf001, 2'h2, ERR_DATA_RANGE},
        '{OP_MODE_LIST, 16'h0, 2'h0, 16'h0}, '{OP_QRY_MODE, 16'h0, 2'h1, REPLY_LIST},
        '{OP_FUNC_MODE, 16'h1, 2'h2, ERR_CONFLICT}, '{OP_MODE_FIX, 16'h0, 2'h0, 16'h0},
        '{OP_QRY_LEVEL, 16'h0, 2'h1, 16'h0}, '{omr_op_t'(5'h1f), 16'h0, 2'h2, ERR_COMMAND}};
    always #2.5 core_clk_i = ~core_clk_i;
    omr_host u_omr_host (.core_clk_i(core_clk_i), .req_o(req));
    omr_core #(.TICK_CYCLES(4), .MAX_LEVEL(16'hf000)) u_omr_core (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .req_i(req), .ans_o(ans), .err_o(err), .seq_done_i(seq_done), .seq_run_o(seq_run),
        .constant_current_flag_i(cc_flag), .constant_level_flag_i(cv_flag), .level_o(level),
        .curr_set_o(curr_set), .curr_lim_o(curr_lim), .dac_code_o(dac), .current_mode_o(cur_mode),
        .auto_scale_enable_o(auto_on), .op_summary_o(summary));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // answer stands only in the cycle after the taking edge; cmd returns inside it
    task automatic run(input omr_op_t op, input logic [15:0] a, input logic [1:0] k, input logic [15:0] d);
        u_omr_host.cmd(op, a);
        chk("answer valid", {15'h0, k == 2'h1}, {15'h0, ans.valid});
        chk("error valid", {15'h0, k == 2'h2}, {15'h0, err.valid});
        if (k != 2'h0) chk("reply", d, (k == 2'h1) ? ans.data : err.code);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #10000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i) rst_i = 1'b0;
        chk("auto after reset", 16'h1, {15'h0, auto_on});
        foreach (rows[i]) run(rows[i].op, rows[i].a, rows[i].k, rows[i].d);
        chk("auto after range", 16'h0, {15'h0, auto_on});
        run(OP_FUNC_MODE, 16'h1, 2'h0, 16'h0);
        chk("current mode", 16'h1, {15'h0, cur_mode});
        run(OP_SET_CURR, 16'h0100, 2'h0, 16'h0);
        run(OP_SET_RANGE, 16'h4, 2'h0, 16'h0);
        run(OP_QRY_RANGE, 16'h0, 2'h1, RANGE_QUARTER);
        chk("dac current quarter", 16'h0400, dac);
        run(OP_FUNC_MODE, 16'h0, 2'h0, 16'h0);
        run(OP_QRY_RANGE, 16'h0, 2'h1, RANGE_FULL);
        run(OP_RESET, 16'h0, 2'h0, 16'h0);
        chk("auto after reset cmd", 16'h1, {15'h0, auto_on});
        run(OP_AUTO_C, 16'h0, 2'h0, 16'h0);
        chk("auto off by amp write", 16'h0, {15'h0, auto_on});
        run(OP_AUTO_V, 16'h1, 2'h0, 16'h0);
        chk("auto on again", 16'h1, {15'h0, auto_on});
        run(OP_SET_LEVEL, 16'h0010, 2'h0, 16'h0);
        chk("dac auto quarter", 16'h0040, dac);
        run(OP_MODE_TRAN, 16'h1, 2'h0, 16'h0);
        run(OP_QRY_MODE, 16'h0, 2'h1, REPLY_TRANS);
        u_omr_host.cmd(OP_SET_LEVEL, 16'h0020);
        @(negedge core_clk_i);
        chk("pulse level", 16'h0020, level);
        repeat (8) @(negedge core_clk_i);
        chk("restored level", 16'h0010, level);
        run(OP_SET_CURR, 16'h0200, 2'h0, 16'h0);
        run(OP_MODE_LIST, 16'h0, 2'h0, 16'h0);
        chk("list running", 16'h1, {15'h0, seq_run});
        chk("limit copied", 16'h0200, curr_lim);
        run(OP_SEQ_LEVEL, 16'h0010, 2'h2, ERR_CONFLICT);
        run(OP_MODE_TRAN, 16'h1, 2'h2, ERR_CONFLICT);
        seq_done = 1'b1;
        @(negedge core_clk_i);
        seq_done = 1'b0;
        chk("list ended", 16'h0, {15'h0, seq_run});
        run(OP_QRY_MODE, 16'h0, 2'h1, REPLY_FIXED);
        run(OP_MODE_LIST, 16'h0, 2'h0, 16'h0);
        run(OP_MODE_FIX, 16'h0, 2'h0, 16'h0);
        chk("fix level", 16'h0, level);
        chk("fix current", 16'h0, curr_set);
        chk("fix limit", 16'h0, curr_lim);
        cc_flag = 1'b1;
        cv_flag = 1'b1;
        repeat (5) @(negedge core_clk_i);
        run(OP_QRY_COND, 16'h0, 2'h1, 16'h0500);
        chk("summary set", 16'h1, {15'h0, summary});
        run(OP_QRY_EVT, 16'h0, 2'h1, 16'h0500);
        run(OP_QRY_EVT, 16'h0, 2'h1, 16'h0);
        chk("summary clear", 16'h0, {15'h0, summary});
        cc_flag = 1'b0;
        repeat (4) @(negedge core_clk_i);
        cc_flag = 1'b1;
        @(negedge core_clk_i);
        u_omr_host.cmd(OP_QRY_EVT, 16'h0);
        chk("read in rise cycle", 16'h0, ans.data);
        run(OP_QRY_EVT, 16'h0, 2'h1, 16'h0400);
        finish_test();
    end
endmodule // tb
`default_nettype wire
